// *** logic/ssio_defines.svh ***
// Offsets, field positions, reset values and counts of the serial unit.
// Assumes an 8-bit AXI4-Lite byte address, one word per register.
`ifndef SSIO_DEFINES_SVH
`define SSIO_DEFINES_SVH
`define SSIO_ADDR_W 8
`define SSIO_OFF_CONTROL_ONE 8'h00
`define SSIO_OFF_DATA_BUFFER 8'h04
`define SSIO_OFF_STATUS 8'h08
`define SSIO_OFF_BAUD_ZERO 8'h0C
`define SSIO_CR1_START 7
`define SSIO_CR1_ABORT 6
`define SSIO_CR1_MODE_HI 5
`define SSIO_CR1_MODE_LO 4
`define SSIO_CR1_ONE 3
`define SSIO_CR1_RATE_HI 2
`define SSIO_CR2_MODE_HI 3
`define SSIO_CR2_MODE_LO 2
`define SSIO_CR2_MODE_RESET 2'h1
`define SSIO_SR_ACTIVE 3
`define SSIO_SR_SHIFT 2
`define SSIO_SR_ONES 8'hF3
`define SSIO_BR0_IDLE 6
`define SSIO_BR0_ONES 8'hBE
`define SSIO_MODE_TX 2'h0
`define SSIO_MODE_DUPLEX 2'h2
`define SSIO_MODE_RX 2'h3
`define SSIO_RATE_EXT 3'h7
`define SSIO_HALF_BASE 8'h02
`define SSIO_LAST_BIT 3'h7
`define SSIO_RESP_OKAY 2'h0
`define SSIO_RESP_SLVERR 2'h2
`endif

// *** logic/ssio_pkg.sv ***
// Types shared by the serial unit modules.
// Assumes nothing beyond a SystemVerilog compiler.
package ssio_pkg;
  typedef enum logic [1:0] {
    SSIO_IDLE,
    SSIO_WAIT,
    SSIO_SHIFT
  } ssio_state_t;
  typedef logic [2:0] ssio_rate_t;
endpackage : ssio_pkg

// *** logic/ssio_link_if.sv ***
// Carrier between the core, its pin synchroniser and its rate generator.
// Assumes all three modules run on aclk.
`timescale 1ns/100ps
interface ssio_link_if;
  logic sck_s;
  logic si_s;
  logic tick;
  logic run;
  ssio_pkg::ssio_rate_t rate;
  modport sync_side(output sck_s, output si_s);
  modport gen_side(input run, input rate, output tick);
  modport core(input sck_s, input si_s, input tick, output run, output rate);
endinterface : ssio_link_if

// *** logic/ssio_sync.sv ***
// Two-flop synchronisers for the clock pin and the data-in pin.
// Assumes both pins are asynchronous to aclk.
`timescale 1ns/100ps
module ssio_sync (
  // Clock and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Raw pins: bit 0 clock, bit 1 data in
  input wire logic [1:0] pins,
  // Synchronised levels
  ssio_link_if.sync_side lnk
);
  import ssio_pkg::*;
  logic [1:0] synced;
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      logic q1;
      logic q2;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          q1 <= 1'b1;
          q2 <= 1'b1;
        end else if (ce) begin
          q1 <= pins[i];
          q2 <= q1;
        end
      end
      assign synced[i] = q2;
    end
  endgenerate
  assign lnk.sck_s = synced[0];
  assign lnk.si_s = synced[1];
endmodule : ssio_sync

// *** logic/ssio_clkgen.sv ***
// Serial clock rate generator: a tick every half period of the chosen rate.
// Assumes run drops whenever the clock must stand still.
`timescale 1ns/100ps
`include "ssio_defines.svh"
module ssio_clkgen (
  // Clock and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Rate select and tick
  ssio_link_if.gen_side lnk
);
  import ssio_pkg::*;
  logic [7:0] cnt;
  logic tick;
  wire [7:0] half = 8'(`SSIO_HALF_BASE << lnk.rate);
  wire at_end = (cnt >= half - 8'h01);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else if (ce) begin
      cnt <= (!lnk.run || at_end) ? 8'h00 : cnt + 8'h01;
      tick <= lnk.run && at_end;
    end
  end
  assign lnk.tick = tick;
endmodule : ssio_clkgen

// *** logic/ssio_top.sv ***
// Synchronous serial unit, 8-bit LSB-first frames, AXI4-Lite registers.
// Assumes aclk at 200 MHz; pins are asynchronous and are synchronised here.
// Contract
// - Status read and control two write share one address.
// - Status bit 3 shows a transfer in progress.
// - Status bit 2 shows the shift register shifting.
// - Baud bit 6 set keeps running in idle; clear halts.
// - Clock select 111 takes the serial clock from the pin.
// - Other clock selects give seven internal rates driven out.
// - Clock pin output goes high when a transfer begins.
// - Internal clock waits while the buffer is unserviced.
// - Transmit changes on falling edge, receive samples rising edge.
// - Start moves the transmit byte to the shifter, sent LSB first.
// - That move empties the buffer and raises the buffer interrupt; the code raises it in mode 00 only, not in duplex.
// - Internal transmit clock stops after 8 bits until buffer written.
// - Data out keeps the previous last bit until first falling edge.
// - Clearing start in transmit finishes the byte, then ends.
// - Abort bit stops at once and clears the active flag.
// - External transmit without stop or data sends a dummy, then stops.
// - Receive shifts LSB first; 8 bits go to buffer with interrupt.
// - Internal receive clock waits until the byte is read.
// - Clearing start in receive completes the byte, then ends.
// - Changing transfer mode discards buffer contents.
// - Mode 00 transmit, 01 reserved, 10 duplex, 11 receive.
// - Control one bit 7 starts with 1, stops with 0.
// - Buffer has separate write and read storage.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "ssio_defines.svh"
module ssio_top (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [`SSIO_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [`SSIO_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Low-power idle request
  input wire logic idle_req,
  // Serial pins
  input wire logic clock_pin_in,
  output logic clock_pin_out,
  output logic clock_pin_oe,
  output logic data_out,
  input wire logic data_in,
  // Buffer interrupt
  output logic buffer_irq
);
  import ssio_pkg::*;

  ssio_link_if lnk ();

  ssio_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pins({data_in, clock_pin_in}),
    .lnk(lnk.sync_side)
  );

  ssio_clkgen u_clkgen (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .lnk(lnk.gen_side)
  );

  // Control state
  logic start;
  logic abort;
  logic [1:0] mode;
  ssio_rate_t rate;
  logic [1:0] iface_mode;
  logic idle_run;
  logic baud_bit0;
  // Data path state
  logic [7:0] tx_buf;
  logic tx_full;
  logic [7:0] rx_buf;
  logic rx_full;
  logic [7:0] shreg;
  logic [7:0] rxsh;
  logic [2:0] bitcnt;
  logic dummy;
  logic sck_prev;
  ssio_state_t state;
  ssio_state_t next_state;
  // Bus holding registers
  logic [`SSIO_ADDR_W-1:0] waddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic [`SSIO_ADDR_W-1:0] raddr_q;

  // Bus decode
  wire wr_do = !awready && !wready && !bvalid;
  wire rd_do = !arready && !rvalid;
  wire w_cr1 = (waddr_q == `SSIO_OFF_CONTROL_ONE);
  wire w_data = (waddr_q == `SSIO_OFF_DATA_BUFFER);
  wire w_cr2 = (waddr_q == `SSIO_OFF_STATUS);
  wire w_br0 = (waddr_q == `SSIO_OFF_BAUD_ZERO);
  wire w_hit = w_cr1 || w_data || w_cr2 || w_br0;
  wire wr_lane = wr_do && wstrb0_q;
  wire cr1_wr = wr_lane && w_cr1;
  wire data_wr = wr_lane && w_data;
  wire cr2_wr = wr_lane && w_cr2;
  wire br0_wr = wr_lane && w_br0;
  wire r_cr1 = (raddr_q == `SSIO_OFF_CONTROL_ONE);
  wire r_data = (raddr_q == `SSIO_OFF_DATA_BUFFER);
  wire r_sr = (raddr_q == `SSIO_OFF_STATUS);
  wire r_br0 = (raddr_q == `SSIO_OFF_BAUD_ZERO);
  wire r_hit = r_cr1 || r_data || r_sr || r_br0;
  wire data_rd = rd_do && r_data;

  wire start_wr = cr1_wr && wdata_q[`SSIO_CR1_START] && !wdata_q[`SSIO_CR1_ABORT];
  wire abort_wr = cr1_wr && wdata_q[`SSIO_CR1_ABORT];
  wire [1:0] new_mode = wdata_q[`SSIO_CR1_MODE_HI:`SSIO_CR1_MODE_LO];
  wire mode_chg = cr1_wr && (new_mode != mode);

  wire tx_en = (mode == `SSIO_MODE_TX) || (mode == `SSIO_MODE_DUPLEX);
  wire rx_en = (mode == `SSIO_MODE_RX) || (mode == `SSIO_MODE_DUPLEX);
  wire ext = (rate == `SSIO_RATE_EXT);
  wire halted = idle_req && !idle_run;
  wire in_shift = (state == SSIO_SHIFT) && !halted;

  wire int_fall = lnk.tick && clock_pin_out;
  wire int_rise = lnk.tick && !clock_pin_out;
  wire ext_fall = sck_prev && !lnk.sck_s;
  wire ext_rise = !sck_prev && lnk.sck_s;
  wire fall = in_shift && (ext ? ext_fall : int_fall);
  wire rise = in_shift && (ext ? ext_rise : int_rise);
  wire byte_done = rise && (bitcnt == `SSIO_LAST_BIT);

  wire tx_ok = !tx_en || tx_full || ext;
  wire rx_ok = !rx_en || !rx_full || ext;
  wire load = (state == SSIO_WAIT) && start && tx_ok && rx_ok && !halted;
  wire dummy_go = byte_done && start && !dummy && ext && tx_en && !tx_full;

  // internal clock runs only while shifting
  assign lnk.run = in_shift && !ext;
  assign lnk.rate = rate;

  always_comb begin
    next_state = state;
    if (abort_wr) begin
      next_state = SSIO_IDLE;
    end else begin
      case (state)
        SSIO_IDLE: begin
          if (start_wr) begin
            next_state = SSIO_WAIT;
          end
        end
        SSIO_WAIT: begin
          if (!start) begin
            next_state = SSIO_IDLE;
          end else if (load) begin
            next_state = SSIO_SHIFT;
          end
        end
        SSIO_SHIFT: begin
          if (byte_done) begin
            if (!start || dummy) begin
              next_state = SSIO_IDLE;
            end else if (dummy_go) begin
              next_state = SSIO_SHIFT;
            end else begin
              next_state = SSIO_WAIT;
            end
          end
        end
        default: next_state = SSIO_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SSIO_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Control one fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start <= 1'b0;
      abort <= 1'b0;
      mode <= `SSIO_MODE_TX;
      rate <= 3'h0;
    end else if (ce && cr1_wr) begin
      start <= wdata_q[`SSIO_CR1_START];
      abort <= wdata_q[`SSIO_CR1_ABORT];
      mode <= new_mode;
      rate <= wdata_q[`SSIO_CR1_RATE_HI:0];
    end
  end

  // Control two and baud zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iface_mode <= `SSIO_CR2_MODE_RESET;
      idle_run <= 1'b0;
      baud_bit0 <= 1'b0;
    end else if (ce) begin
      if (cr2_wr) begin
        iface_mode <= wdata_q[`SSIO_CR2_MODE_HI:`SSIO_CR2_MODE_LO];
      end
      if (br0_wr) begin
        idle_run <= wdata_q[`SSIO_BR0_IDLE];
        baud_bit0 <= wdata_q[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf <= 8'h00;
      tx_full <= 1'b0;
    end else if (ce) begin
      if (data_wr) begin
        tx_buf <= wdata_q;
      end
      // Set wins over the load that empties it
      if (data_wr) begin
        tx_full <= 1'b1;
      end else if (mode_chg || (load && tx_en)) begin
        tx_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf <= 8'h00;
      rx_full <= 1'b0;
    end else if (ce) begin
      if (mode_chg) begin
        rx_buf <= 8'h00;
      end else if (byte_done && rx_en) begin
        rx_buf <= {lnk.si_s, rxsh[7:1]};
      end
      if (byte_done && rx_en) begin
        rx_full <= 1'b1;
      end else if (data_rd || mode_chg) begin
        rx_full <= 1'b0;
      end
    end
  end

  // Shifters and bit counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg <= 8'h00;
      rxsh <= 8'h00;
      bitcnt <= 3'h0;
    end else if (ce) begin
      if (load) begin
        if (tx_en) begin
          shreg <= tx_buf;
        end
        bitcnt <= 3'h0;
      end else if (rise) begin
        rxsh <= {lnk.si_s, rxsh[7:1]};
        bitcnt <= bitcnt + 3'h1;
      end
    end
  end

  // Serial clock, data out and pin drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_pin_out <= 1'b1;
      clock_pin_oe <= 1'b0;
      data_out <= 1'b1;
      sck_prev <= 1'b1;
    end else if (ce) begin
      sck_prev <= lnk.sck_s;
      clock_pin_oe <= !ext;
      if (start_wr || state != SSIO_SHIFT) begin
        clock_pin_out <= 1'b1;
      end else if (int_fall || int_rise) begin
        clock_pin_out <= !clock_pin_out;
      end
      // bit out on falling edge only
      if (fall && tx_en) begin
        data_out <= shreg[bitcnt];
      end
    end
  end

  // Dummy flag and buffer interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dummy <= 1'b0;
      buffer_irq <= 1'b0;
    end else if (ce) begin
      if (state == SSIO_IDLE) begin
        dummy <= 1'b0;
      end else if (dummy_go) begin
        dummy <= 1'b1;
      end
      buffer_irq <= (load && mode == `SSIO_MODE_TX) || (byte_done && rx_en);
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `SSIO_RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        waddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wdata_q <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
      if (wr_do) begin
        bvalid <= 1'b1;
        bresp <= w_hit ? `SSIO_RESP_OKAY : `SSIO_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  wire [7:0] cr1_rd = {start, abort, mode, 1'b1, rate};
  wire [7:0] sr_rd = `SSIO_SR_ONES
    | (8'((state != SSIO_IDLE)) << `SSIO_SR_ACTIVE)
    | (8'((state == SSIO_SHIFT)) << `SSIO_SR_SHIFT);
  wire [7:0] br0_rd = `SSIO_BR0_ONES | (8'(idle_run) << `SSIO_BR0_IDLE) | 8'(baud_bit0);
  wire [7:0] rd_byte = r_cr1 ? cr1_rd : r_data ? rx_buf : r_sr ? sr_rd : r_br0 ? br0_rd : 8'h00;

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `SSIO_RESP_OKAY;
      raddr_q <= '0;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        raddr_q <= araddr;
      end
      if (rd_do) begin
        rvalid <= 1'b1;
        rdata <= {24'h000000, rd_byte};
        rresp <= r_hit ? `SSIO_RESP_OKAY : `SSIO_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : ssio_top

// *** testbench/ssio_top_chk.sv ***
// Concurrent checks on the serial unit top-level ports.
// Assumes ce high during checked traffic; bound onto ssio_top below.
`timescale 1ns/100ps
`include "ssio_defines.svh"
module ssio_top_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [`SSIO_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Serial pins and interrupt
  input wire logic clock_pin_out,
  input wire logic clock_pin_oe,
  input wire logic data_out,
  input wire logic buffer_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);
  reset_idle_a: assert property ($rose(aresetn) |-> clock_pin_out && data_out && !buffer_irq)
    else $error("pins not idle after reset");
  irq_pulse_a: assert property (buffer_irq |=> !buffer_irq)
    else $error("buffer interrupt longer than one cycle");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  read_lat_a: assert property (arvalid && arready |=> !arready && !rvalid ##1 rvalid)
    else $error("read answer late or early");
  write_lat_a: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write answer late or early");
  unmapped_read_a: assert property (arvalid && arready && araddr > 8'h0C |->
    ##2 rresp == `SSIO_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  data_fall_a: assert property ($changed(data_out) && clock_pin_oe |-> !clock_pin_out)
    else $error("data out moved outside clock low");
  clock_low_a: assert property ($fell(clock_pin_out) |=> !clock_pin_out)
    else $error("serial clock low phase too short");
  ready_busy_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  cover property (buffer_irq);
  cover property ($fell(clock_pin_out));
  cover property (rvalid && rresp == `SSIO_RESP_SLVERR);
endmodule : ssio_top_chk
bind ssio_top ssio_top_chk chk_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe), .data_out(data_out),
  .buffer_irq(buffer_irq));

// *** testbench/ssio_peer.sv ***
// Far-side serial peer: samples data out, drives data in, makes an external clock.
// Assumes the clock pin idles high; bytes are LSB first.
`timescale 1ns/100ps
module ssio_peer (
  // Device pins
  input wire logic clock_pin_out,
  input wire logic clock_pin_oe,
  input wire logic data_out,
  output logic clock_pin_in,
  output logic data_in,
  // Bench side
  input wire logic [7:0] send_byte,
  output logic [7:0] got_byte,
  output int frames
);
  wire sck;
  int rises;
  int bit_idx;
  assign sck = clock_pin_oe ? clock_pin_out : clock_pin_in;
  initial begin
    clock_pin_in = 1'b1;
    data_in = 1'b1;
  end
  always @(posedge sck) begin
    got_byte = {data_out, got_byte[7:1]};
    rises = rises + 1;
    if (rises == 8) begin
      rises = 0;
      bit_idx = 0;
      frames = frames + 1;
      // Inverted line: never shows the last bit
      data_in = ~data_in;
    end
  end
  always @(negedge sck) begin
    data_in = send_byte[bit_idx[2:0]];
    bit_idx = bit_idx + 1;
  end
  task clear();
    rises = 0;
    bit_idx = 0;
    frames = 0;
    got_byte = 8'h00;
  endtask : clear
  // external clock, one byte, still between bytes
  task ext_byte();
    repeat (8) begin
      #62.5 clock_pin_in = 1'b0;
      #62.5 clock_pin_in = 1'b1;
    end
  endtask : ext_byte
endmodule : ssio_peer

// *** testbench/ssio_top_test.sv ***
// Self-checking bench for the serial unit over AXI4-Lite.
// Assumes ssio_top, ssio_peer and the bound checker are compiled first.
`timescale 1ns/100ps
`include "ssio_defines.svh"
module ssio_top_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, send_byte = 8'h00, got_byte;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic idle_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, buffer_irq, data_in, clock_pin_in;
  logic clock_pin_out, clock_pin_oe, data_out;
  logic [1:0] bresp, rresp;
  int frames;
  int miscompares = 0;
  int checks = 0;
  int irqs = 0;
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) if (buffer_irq === 1'b1) irqs <= irqs + 1;
  ssio_top ssio_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .idle_req(idle_req), .clock_pin_in(clock_pin_in),
    .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe), .data_out(data_out),
    .data_in(data_in), .buffer_irq(buffer_irq));
  ssio_peer ssio_peer_inst (.clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe),
    .data_out(data_out), .clock_pin_in(clock_pin_in), .data_in(data_in),
    .send_byte(send_byte), .got_byte(got_byte), .frames(frames));
  task end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] want);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    // Ready stays up: a back-to-back call must not touch it twice in one step
    check(bresp, want);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] want, input logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    check(rresp, resp);
    if (want !== 32'hx) check(rdata, want);
  endtask : rd
  task cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask : cycles
  task wait_frame(input int n);
    int k;
    k = 0;
    while (frames < n && k < 3000) begin
      @(posedge aclk);
      k++;
    end
    check(frames, n);
  endtask : wait_frame
  task t_regs();
    rd(`SSIO_OFF_CONTROL_ONE, 32'h08, `SSIO_RESP_OKAY);
    rd(`SSIO_OFF_BAUD_ZERO, 32'hBE, `SSIO_RESP_OKAY);
    rd(8'h10, 32'h0, `SSIO_RESP_SLVERR);
    wr(8'h20, 32'h1, `SSIO_RESP_SLVERR);
    wr(`SSIO_OFF_STATUS, 32'h04, `SSIO_RESP_OKAY);
    rd(`SSIO_OFF_STATUS, 32'hF3, `SSIO_RESP_OKAY);
    wr(`SSIO_OFF_BAUD_ZERO, 32'h40, `SSIO_RESP_OKAY);
    rd(`SSIO_OFF_BAUD_ZERO, 32'hFE, `SSIO_RESP_OKAY);
    wr(`SSIO_OFF_BAUD_ZERO, 32'h00, `SSIO_RESP_OKAY);
  endtask : t_regs
  task t_tx();
    ssio_peer_inst.clear();
    wr(`SSIO_OFF_DATA_BUFFER, 32'h5A, `SSIO_RESP_OKAY);
    idle_req <= 1'b1;
    wr(`SSIO_OFF_CONTROL_ONE, 32'h80, `SSIO_RESP_OKAY);
    rd(`SSIO_OFF_STATUS, 32'hFB, `SSIO_RESP_OKAY);
    cycles(30);
    check({clock_pin_out, data_out, frames[0]}, 3'b110);
    idle_req <= 1'b0;
    wait_frame(1);
    check({got_byte, irqs[3:0]}, {8'h5A, 4'h1});
    cycles(40);
    check({clock_pin_out, frames[1:0]}, 3'b101);
    wr(`SSIO_OFF_DATA_BUFFER, 32'hC3, `SSIO_RESP_OKAY);
    wait_frame(2);
    check(got_byte, 8'hC3);
    wr(`SSIO_OFF_CONTROL_ONE, 32'h00, `SSIO_RESP_OKAY);
    rd(`SSIO_OFF_STATUS, 32'hF3, `SSIO_RESP_OKAY);
  endtask : t_tx
  task t_rx();
    ssio_peer_inst.clear();
    send_byte <= 8'h3C;
    wr(`SSIO_OFF_CONTROL_ONE, 32'h32, `SSIO_RESP_OKAY);
    wr(`SSIO_OFF_CONTROL_ONE, 32'hB2, `SSIO_RESP_OKAY);
    wait_frame(1);
    cycles(60);
    check({clock_pin_out, frames[1:0], irqs[3:0]}, {3'b101, 4'h3});
    wr(`SSIO_OFF_CONTROL_ONE, 32'h32, `SSIO_RESP_OKAY);
    rd(`SSIO_OFF_DATA_BUFFER, 32'h3C, `SSIO_RESP_OKAY);
    rd(`SSIO_OFF_STATUS, 32'hF3, `SSIO_RESP_OKAY);
    wr(`SSIO_OFF_CONTROL_ONE, 32'h02, `SSIO_RESP_OKAY);
    rd(`SSIO_OFF_DATA_BUFFER, 32'h00, `SSIO_RESP_OKAY);
  endtask : t_rx
  task t_abort_ext();
    ssio_peer_inst.clear();
    wr(`SSIO_OFF_CONTROL_ONE, 32'h00, `SSIO_RESP_OKAY);
    wr(`SSIO_OFF_DATA_BUFFER, 32'hFF, `SSIO_RESP_OKAY);
    wr(`SSIO_OFF_CONTROL_ONE, 32'h80, `SSIO_RESP_OKAY);
    wr(`SSIO_OFF_CONTROL_ONE, 32'h40, `SSIO_RESP_OKAY);
    rd(`SSIO_OFF_STATUS, 32'hF3, `SSIO_RESP_OKAY);
    wr(`SSIO_OFF_CONTROL_ONE, 32'h07, `SSIO_RESP_OKAY);
    ssio_peer_inst.clear();
    wr(`SSIO_OFF_DATA_BUFFER, 32'h96, `SSIO_RESP_OKAY);
    check(clock_pin_oe, 1'b0);
    wr(`SSIO_OFF_CONTROL_ONE, 32'h87, `SSIO_RESP_OKAY);
    rd(`SSIO_OFF_CONTROL_ONE, 32'h8F, `SSIO_RESP_OKAY);
    ssio_peer_inst.ext_byte();
    cycles(10);
    check(got_byte, 8'h96);
    ssio_peer_inst.ext_byte();
    cycles(10);
    rd(`SSIO_OFF_STATUS, 32'hF3, `SSIO_RESP_OKAY);
  endtask : t_abort_ext
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_abort_ext();
    end_sim();
  end
endmodule : ssio_top_test
